// ### rtl/qbp_pkg.sv
// Shared constants and carrier types for the parallel port block
package qbp_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int        BYTE_W    = 8;
    localparam int        NIB_W     = 4;
    localparam int        HEX_W     = 6;
    localparam int        PIN_CNT   = 34;
    localparam int        HEX_PINS  = 6;
    localparam int        HEX_MIN   = 3;
    localparam int        PWM8_CNT  = 6;
    localparam int        PWM14_CNT = 2;

    // ------------------------------------------------------------
    // Port selects for latch writes and reads
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_A   = 3'h0;
    localparam logic [2:0] SEL_B   = 3'h1;
    localparam logic [2:0] SEL_NIB = 3'h2;
    localparam logic [2:0] SEL_D   = 3'h3;
    localparam logic [2:0] SEL_E   = 3'h4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam logic [5:0] HEX_RST   = 6'h3f;

    // ------------------------------------------------------------
    // Bit positions in the third byte port and the hex port
    // ------------------------------------------------------------
    localparam int D_PAR  = 0;
    localparam int D_TXD  = 1;
    localparam int D_XI0  = 1;
    localparam int D_INT0 = 2;
    localparam int D_INT1 = 3;
    localparam int D_T0   = 4;
    localparam int D_T1   = 5;
    localparam int D_TST  = 6;
    localparam int D_XI1  = 7;
    localparam int E_A17  = 0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       en;
        logic [2:0] sel;
        logic [7:0] data;
    } qbp_wr_s;

    typedef struct packed {
        logic       en;
        logic       rmw;
        logic [2:0] sel;
    } qbp_rd_s;

    typedef struct packed {
        logic [3:0] c;
        logic [5:0] e;
        logic [7:0] d;
        logic [7:0] b;
        logic [7:0] a;
    } qbp_pins_s;

    typedef struct packed {
        logic [5:0] e;
        logic [7:0] d;
        logic [7:0] b;
        logic [7:0] a;
    } qbp_drv_s;

    typedef struct packed {
        logic xInt0;
        logic int0;
        logic int1;
        logic t0;
        logic t1;
        logic xInt1;
        logic rxd;
    } qbp_alt_s;
endpackage

// ### rtl/qbp_port_block.sv
// Parallel port latches, pin drivers, read paths and alternate functions
//
// Contract
// - Thirty-four pins exist, with three 8-bit bidirectional byte ports.
// - The 4-bit nibble port is input only and never drives its pins.
// - The hex port has six bits, of which only the first E_PINS reach pins.
// - Every byte and hex port pin is programmable as input or output except while PWM, parity, A17 or a low TXD drives it.
// - A plain read returns latch AND pin level.
// - A read-modify-write read returns the latch, not the pin.
// - A latch bit of one makes the pin an input, and writing one restores input use.
// - Reset loads ones into every latch so all pins are inputs.
// - The first byte port is open-drain; a one leaves the pin floating.
// - Quasi ports drive high strongly for one clock only on a latch 0 to 1 change.
// - Secondary inputs of the third byte port follow the pin while its latch bit is one.
// - PWM enable bits route 8-bit channels 0-5 to second port bits 0-5 and 14-bit 0-1 to 6-7.
// - Third port bits 1-5 and 7 feed interrupts and timer inputs, bits 1 and 7 serial.
`timescale 1ns/100ps
module qbp_port_block
    import qbp_pkg::*;
#(
    parameter int E_PINS = HEX_PINS
) (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire qbp_wr_s    wrReq,
    input  wire qbp_rd_s    rdReq,
    output      logic [7:0] rdData,
    output      logic       rdValid,
    input  wire qbp_pins_s  pinIn,
    output      qbp_drv_s   pinOut,
    output      qbp_drv_s   pinOe,
    input  wire logic [7:0] pwmEnable,
    input  wire logic [5:0] pwm8,
    input  wire logic [1:0] pwm14,
    input  wire logic       fieldParityPinEnable,
    input  wire logic       oddEven,
    input  wire logic       txd,
    input  wire logic       highAddrBit17Select,
    input  wire logic       addr17,
    output      qbp_alt_s   altIn,
    output      logic       testMode
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (E_PINS < HEX_MIN || E_PINS > HEX_W) begin : g_chk
        $error("E_PINS out of range");
    end

    if ($bits(qbp_pins_s) != PIN_CNT) begin : g_pins
        $error("pin count does not match the port set");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] readPort(input logic [7:0] lat,
                                            input logic [7:0] pin,
                                            input logic       rmw);
        readPort = rmw ? lat : (lat & pin);
    endfunction

    function automatic logic [7:0] nextLatch(input logic [7:0] lat,
                                             input logic       hit);
        nextLatch = hit ? wrReq.data : lat;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    qbp_pins_s syncMeta;
    qbp_pins_s pinSync;

    // Reset to the pulled-up idle level so nothing unknown leaks out after reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            syncMeta <= '1;
            pinSync  <= '1;
        end else begin
            syncMeta <= pinIn;
            pinSync  <= syncMeta;
        end
    end

    // ------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------
    logic [7:0] latchA;
    logic [7:0] latchB;
    logic [7:0] latchD;
    logic [5:0] latchE;

    wire        hitA   = wrReq.en && wrReq.sel == SEL_A;
    wire        hitB   = wrReq.en && wrReq.sel == SEL_B;
    wire        hitD   = wrReq.en && wrReq.sel == SEL_D;
    wire        hitE   = wrReq.en && wrReq.sel == SEL_E;
    wire  [7:0] next_latchA = nextLatch(latchA, hitA);
    wire  [7:0] next_latchB = nextLatch(latchB, hitB);
    wire  [7:0] next_latchD = nextLatch(latchD, hitD);
    wire  [7:0] next_latchE = nextLatch({2'h3, latchE}, hitE);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            latchA <= LATCH_RST;
            latchB <= LATCH_RST;
            latchD <= LATCH_RST;
            latchE <= HEX_RST;
        end else begin
            latchA <= next_latchA;
            latchB <= next_latchB;
            latchD <= next_latchD;
            latchE <= next_latchE[5:0];
        end
    end

    // ------------------------------------------------------------
    // Strong pull-up pulses on 0 to 1 latch changes
    // ------------------------------------------------------------
    wire  [7:0] riseB = ~latchB & next_latchB;
    wire  [7:0] riseD = ~latchD & next_latchD;
    wire  [5:0] riseE = ~latchE & next_latchE[5:0];

    // ------------------------------------------------------------
    // Next pin drive
    // ------------------------------------------------------------
    wire  [7:0] pwmAll  = {pwm14, pwm8};
    wire  [7:0] effD    = {next_latchD[7:2],
                           next_latchD[D_TXD] & txd,
                           fieldParityPinEnable ? oddEven : next_latchD[D_PAR]};
    wire  [7:0] altD    = {6'h00, 1'b0, fieldParityPinEnable};
    wire        e0Addr  = ~highAddrBit17Select;
    wire  [5:0] effE    = {next_latchE[5:1], e0Addr ? addr17 : next_latchE[E_A17]};
    wire  [5:0] eMask   = 6'((7'h01 << E_PINS) - 7'h01);

    qbp_drv_s next_pinOut;
    qbp_drv_s next_pinOe;

    assign next_pinOut.a = 8'h00;
    assign next_pinOe.a  = ~next_latchA;
    assign next_pinOut.b = (pwmEnable & pwmAll) | (~pwmEnable & next_latchB);
    assign next_pinOe.b  = pwmEnable | ~next_latchB | riseB;
    assign next_pinOut.d = effD;
    assign next_pinOe.d  = altD | ~effD | riseD;
    assign next_pinOut.e = effE & eMask;
    assign next_pinOe.e  = ({5'h00, e0Addr} | ~effE | riseE) & eMask;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pinOut <= '0;
            pinOe  <= '0;
        end else begin
            pinOut <= next_pinOut;
            pinOe  <= next_pinOe;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] next_rdData;

    always_comb begin
        case (rdReq.sel)
            SEL_A:   next_rdData = readPort(latchA, pinSync.a, rdReq.rmw);
            SEL_B:   next_rdData = readPort(latchB, pinSync.b, rdReq.rmw);
            SEL_NIB: next_rdData = {4'h0, pinSync.c};
            SEL_D:   next_rdData = readPort(latchD, pinSync.d, rdReq.rmw);
            SEL_E:   next_rdData = readPort({2'h3, latchE},
                                            {2'h3, pinSync.e}, rdReq.rmw) & {2'h0, eMask};
            default: next_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdData  <= rdReq.en ? next_rdData : rdData;
            rdValid <= rdReq.en;
        end
    end

    // ------------------------------------------------------------
    // Secondary inputs of the third byte port, idle high when masked
    // ------------------------------------------------------------
    wire  [7:0] gateD = ~latchD | pinSync.d;
    qbp_alt_s next_altIn;

    assign next_altIn.xInt0 = gateD[D_XI0];
    assign next_altIn.int0  = gateD[D_INT0];
    assign next_altIn.int1  = gateD[D_INT1];
    assign next_altIn.t0    = gateD[D_T0];
    assign next_altIn.t1    = gateD[D_T1];
    assign next_altIn.xInt1 = gateD[D_XI1];
    assign next_altIn.rxd   = gateD[D_XI1];

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            altIn <= '1;
        end else begin
            altIn <= next_altIn;
        end
    end

    // ------------------------------------------------------------
    // Test strap, taken from the pin level seen at the release edge
    // ------------------------------------------------------------
    // Two synchroniser stages: that level reaches pinSync on the second edge, testMode loads on the third
    logic [1:0] strapAge;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            strapAge <= 2'h0;
            testMode <= 1'b0;
        end else begin
            strapAge <= (strapAge == 2'h3) ? strapAge : strapAge + 2'h1;
            testMode <= (strapAge == 2'h2) ? ~pinSync.d[D_TST] : testMode;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic       pastRst;
    logic [1:0] syncAge;
    wire  [5:0] strongD = pinOe.d[7:2] & pinOut.d[7:2];

    always_ff @(posedge ref_clk) begin
        pastRst <= ~nrst;
        if (!nrst) begin
            syncAge <= 2'h0;
        end else if (syncAge != 2'h3) begin
            syncAge <= syncAge + 2'h1;
        end
    end

    property p_reset_ones;
        pastRst |-> (latchA & latchB & latchD) == LATCH_RST && latchE == HEX_RST && pinOe == '0;
    endproperty
    a_reset_ones: assert property (p_reset_ones) else $error("latches not all ones");

    property p_read_and;
        rdReq.en && !rdReq.rmw && rdReq.sel == SEL_B
            |=> rdValid && rdData == $past(latchB & pinSync.b);
    endproperty
    a_read_and: assert property (p_read_and) else $error("plain read not latch and pin");

    property p_read_rmw;
        rdReq.en && rdReq.rmw && rdReq.sel == SEL_D |=> rdData == $past(latchD);
    endproperty
    a_read_rmw: assert property (p_read_rmw) else $error("rmw read not latch");

    property p_open_drain;
        hitA |=> pinOe.a == ~$past(wrReq.data) && pinOut.a == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain wrong");

    property p_pulse_single;
        (strongD & $past(strongD)) == 6'h00;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("pull-up over one clock");

    property p_pulse_cause;
        (strongD & ~(~$past(latchD[7:2]) & latchD[7:2])) == 6'h00;
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pull-up without rise");

    property p_input_float;
        latchD[D_XI1] && $past(latchD[D_XI1]) |-> !pinOe.d[D_XI1];
    endproperty
    a_input_float: assert property (p_input_float) else $error("input pin driven");

    property p_alt_int0;
        ##1 altIn.int0 == $past(latchD[D_INT0] ? pinSync.d[D_INT0] : 1'b1);
    endproperty
    a_alt_int0: assert property (p_alt_int0) else $error("int0 not from pin");

    property p_sync_delay;
        syncAge == 2'h3 |-> pinSync == $past(pinIn, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

    property p_pwm_route;
        pwmEnable[0] |=> pinOe.b[0] && pinOut.b[0] == $past(pwm8[0]);
    endproperty
    a_pwm_route: assert property (p_pwm_route) else $error("pwm not routed");

    property p_nibble_read;
        rdReq.en && rdReq.sel == SEL_NIB |=> rdData == {4'h0, $past(pinSync.c)};
    endproperty
    a_nibble_read: assert property (p_nibble_read) else $error("nibble read wrong");

    property p_hex_mask;
        (pinOe.e & ~eMask) == 6'h00;
    endproperty
    a_hex_mask: assert property (p_hex_mask) else $error("absent hex pin driven");

    c_pulse:    cover property (|strongD);
    c_rmw_read: cover property (rdReq.en && rdReq.rmw ##1 rdValid);
    c_pwm_on:   cover property (pwmEnable != 8'h00 ##1 |pinOe.b);
    c_alt_low:  cover property (!altIn.int0);
    c_alt_mask: cover property (!latchD[D_XI1] ##1 altIn.xInt1);
endmodule

// ### tb/qbp_pin_model.sv
// Pin-side model: external drivers and weak pull-ups on every port pin
`timescale 1ns/100ps
module qbp_pin_model
    import qbp_pkg::*;
(
    input  wire qbp_drv_s  pinOut,
    input  wire qbp_drv_s  pinOe,
    input  wire qbp_pins_s extVal,
    input  wire qbp_pins_s extEn,
    output      qbp_pins_s pinIn
);
    // Device drive wins, then the external source, else the pull-up holds the pin high
    wire logic [7:0] lvlA = (pinOe.a & pinOut.a) | (~pinOe.a & ((extEn.a & extVal.a) | ~extEn.a));
    wire logic [7:0] lvlB = (pinOe.b & pinOut.b) | (~pinOe.b & ((extEn.b & extVal.b) | ~extEn.b));
    wire logic [7:0] lvlD = (pinOe.d & pinOut.d) | (~pinOe.d & ((extEn.d & extVal.d) | ~extEn.d));
    wire logic [5:0] lvlE = (pinOe.e & pinOut.e) | (~pinOe.e & ((extEn.e & extVal.e) | ~extEn.e));
    wire logic [3:0] lvlC = (extEn.c & extVal.c) | ~extEn.c;

    assign pinIn = {lvlC, lvlE, lvlD, lvlB, lvlA};
endmodule

// ### tb/qbp_port_block_tb.sv
// Self-checking testbench for the parallel port block
`timescale 1ns/100ps
module qbp_port_block_tb
    import qbp_pkg::*;
;
    logic       ref_clk   = 1'b0;
    logic       nrst      = 1'b0;
    qbp_wr_s    wrReq     = '0;
    qbp_rd_s    rdReq     = '0;
    logic [7:0] rdData;
    logic       rdValid;
    qbp_pins_s  pinIn;
    qbp_pins_s  extVal    = '0;
    qbp_pins_s  extEn     = '0;
    qbp_drv_s   pinOut;
    qbp_drv_s   pinOe;
    logic [7:0] pwmEnable = '0;
    logic [5:0] pwm8      = '0;
    logic [1:0] pwm14     = '0;
    logic       par       = 1'b0;
    logic       oddEven   = 1'b0;
    logic       txd       = 1'b1;
    logic       a17Sel    = 1'b1;
    logic       addr17    = 1'b0;
    qbp_alt_s   altIn;
    logic       testMode;
    int         fails     = 0;
    int         n_tests   = 0;
    logic [2:0] sels[4]   = '{SEL_A, SEL_B, SEL_D, SEL_E};
    logic [7:0] msk[4]    = '{8'hff, 8'hff, 8'hff, 8'h07};

    always #10 ref_clk = ~ref_clk;

    qbp_port_block #(.E_PINS(3)) u_qbp_port_block (
        .ref_clk(ref_clk), .nrst(nrst), .wrReq(wrReq), .rdReq(rdReq),
        .rdData(rdData), .rdValid(rdValid), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pwmEnable(pwmEnable), .pwm8(pwm8), .pwm14(pwm14),
        .fieldParityPinEnable(par), .oddEven(oddEven), .txd(txd),
        .highAddrBit17Select(a17Sel), .addr17(addr17), .altIn(altIn),
        .testMode(testMode)
    );

    qbp_pin_model u_qbp_pin_model (
        .pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .extEn(extEn), .pinIn(pinIn)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [2:0] s, logic [7:0] v);
        tick(1);
        wrReq = '{1'b1, s, v};
        tick(1);
        wrReq.en = 1'b0;
    endtask

    task automatic rdchk(logic [2:0] s, logic m, logic [7:0] exp);
        tick(1);
        rdReq = '{1'b1, m, s};
        tick(1);
        rdReq.en = 1'b0;
        chk("rdValid", rdValid, 1);
        chk("rdData", rdData, exp);
    endtask

    function automatic logic [7:0] fld(qbp_drv_s v, logic [2:0] s);
        case (s)
            SEL_A: return v.a;
            SEL_B: return v.b;
            SEL_D: return v.d;
            default: return {2'h0, v.e};
        endcase
    endfunction

    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(2);
        nrst = 1'b1;
        tick(1);
        chk("oeRst", pinOe, 0);
        chk("testMode", testMode, 0);
        for (int i = 0; i < 4; i++) begin
            rdchk(sels[i], 1'b1, msk[i]);
        end
        rdchk(SEL_B, 1'b0, 8'hff);
        chk("pinCount", $bits(qbp_pins_s), 34);
        // Quasi ports: strong drive only on a 0 to 1 latch change
        for (int i = 1; i < 4; i++) begin
            wr(sels[i], 8'h00);
            chk("oeLow", fld(pinOe, sels[i]), msk[i]);
            chk("outLow", fld(pinOut, sels[i]), 8'h00);
            wr(sels[i], 8'h01);
            chk("oePulse", fld(pinOe, sels[i]), msk[i]);
            chk("outPulse", fld(pinOut, sels[i]) & 8'h01, 8'h01);
            tick(1);
            chk("oeAfter", fld(pinOe, sels[i]), msk[i] & 8'hfe);
            wr(sels[i], 8'h01);
            chk("oeNoPulse", fld(pinOe, sels[i]), msk[i] & 8'hfe);
            wr(sels[i], 8'hff);
            tick(1);
            chk("oeIdle", fld(pinOe, sels[i]), 8'h00);
        end
        // Open-drain port, pin and latch read paths
        extEn.a = 8'hff;
        extVal.a = 8'h5a;
        tick(3);
        rdchk(SEL_A, 1'b0, 8'h5a);
        wr(SEL_A, 8'h0f);
        chk("oeA", pinOe.a, 8'hf0);
        chk("outA", pinOut.a & pinOe.a, 0);
        tick(2);
        rdchk(SEL_A, 1'b0, 8'h0a);
        rdchk(SEL_A, 1'b1, 8'h0f);
        wr(SEL_A, 8'hff);
        chk("oeA1", pinOe.a, 0);
        extEn.a = 8'h00;
        // Input-only nibble port ignores writes
        extEn.c = 4'hf;
        extVal.c = 4'ha;
        wr(SEL_NIB, 8'h00);
        chk("oeNib", pinOe, 0);
        tick(2);
        rdchk(SEL_NIB, 1'b0, 8'h0a);
        // Secondary inputs follow synchronised pins while the latch is one
        extEn.d = 8'hbe;
        tick(1);
        chk("altEarly", altIn, 7'h7f);
        tick(2);
        chk("altLow", altIn, 7'h00);
        wr(SEL_D, 8'h7d);
        tick(1);
        chk("altMasked", altIn, 7'h43);
        wr(SEL_D, 8'hff);
        extEn.d = 8'h00;
        // Alternate outputs
        pwmEnable = 8'hff;
        pwm8 = 6'h2a;
        pwm14 = 2'h1;
        par = 1'b1;
        oddEven = 1'b1;
        txd = 1'b0;
        a17Sel = 1'b0;
        addr17 = 1'b1;
        tick(2);
        chk("oePwm", pinOe.b, 8'hff);
        chk("outPwm", pinOut.b, 8'h6a);
        chk("oeD", pinOe.d[1:0], 2'h3);
        chk("outD", pinOut.d[1:0], 2'h1);
        chk("oeE", pinOe.e[0], 1);
        chk("outE", pinOut.e[0], 1);
        pwmEnable = 8'h0f;
        tick(2);
        chk("oePwmPart", pinOe.b, 8'h0f);
        chk("testModeLate", testMode, 0);
        tally_and_finish();
    end
endmodule
